// ### rtl/cfc_consts.vh
// register map, field positions and reset values of the channel control bank
`ifndef CFC_CONSTS_VH
`define CFC_CONSTS_VH

`define CFC_ADDR_W          5
`define CFC_ADDR_FUNC       5'h03
`define CFC_ADDR_FREQ       5'h04
`define CFC_FUNC_W          24
`define CFC_FREQ_W          32
`define CFC_FUNC_RESET      24'h000300
`define CFC_FREQ_RESET      32'h00000000
// bits that hold storage; open bits 21:16 and 12:11 read as zero
`define CFC_FUNC_MASK       24'hc0e7ff
`define CFC_MOD_HI          23
`define CFC_MOD_LO          22
`define CFC_NO_DWELL        15
`define CFC_SWEEP_EN        14
`define CFC_LOAD_SRR        13
`define CFC_MUST_ZERO       10
`define CFC_DAC_FS_HI       9
`define CFC_DAC_FS_LO       8
`define CFC_DIG_PD          7
`define CFC_DAC_PD          6
`define CFC_MATCH_PIPE      5
`define CFC_AUTOCLR_SWEEP   4
`define CFC_CLR_SWEEP       3
`define CFC_AUTOCLR_PHASE   2
`define CFC_CLR_PHASE       1
`define CFC_SINE_SEL        0

`endif

// ### rtl/cfc_channel_function_control.v
// per-channel function register and frequency word with update-strobe commit
//
// What this block does
// - bits 23:22 select amplitude, frequency, phase modulation
// - bit 14 enables linear frequency sweep
// - bit 15 no-dwell, ignored without sweep enable
// - bit 13 also reloads ramp timer on update
// - DAC full-scale field bits 9:8 resets to 11
// - bit 7 powers down the digital core
// - bit 6 powers down the converter
// - bit 5 turns on matched pipeline delay
// - bit 4: update clears sweep accumulator one cycle
// - bit 3 clears sweep accumulator storage
// - bit 2: update clears phase accumulator one cycle
// - bit 1 clears phase accumulator storage
// - bit 0 picks cosine (0) or sine (1)
// - function register at address 0x03, three bytes
// - frequency word at address 0x04, 32 bits
// - each channel keeps its own frequency word
`timescale 1ns/1ps
`default_nettype none
`include "cfc_consts.vh"

module cfc_channel_function_control #(
    parameter NUM_CH = 2
) (
    input  wire                          core_clk,
    input  wire                          srst,
    input  wire                          wr_en,
    input  wire [`CFC_ADDR_W-1:0]        wr_addr,
    input  wire [NUM_CH-1:0]             wr_ch_sel,
    input  wire [`CFC_FREQ_W-1:0]        wr_data,
    input  wire                          rd_en,
    input  wire [`CFC_ADDR_W-1:0]        rd_addr,
    input  wire [NUM_CH-1:0]             rd_ch_sel,
    input  wire                          io_update,
    output reg  [`CFC_FREQ_W-1:0]        rd_data_ff,
    output reg                           rd_valid_ff,
    output reg  [2*NUM_CH-1:0]           modulation_type_select_ff,
    output reg  [NUM_CH-1:0]             sweep_en_ff,
    output reg  [NUM_CH-1:0]             no_dwell_ff,
    output reg  [NUM_CH-1:0]             sweep_ramp_rate_reload_ff,
    output reg  [2*NUM_CH-1:0]           dac_fs_ff,
    output reg  [NUM_CH-1:0]             digital_pd_ff,
    output reg  [NUM_CH-1:0]             dac_pd_ff,
    output reg  [NUM_CH-1:0]             match_pipe_ff,
    output reg  [NUM_CH-1:0]             sweep_acc_clr_ff,
    output reg  [NUM_CH-1:0]             phase_acc_clr_ff,
    output reg  [NUM_CH-1:0]             sine_sel_ff,
    output reg  [`CFC_FREQ_W*NUM_CH-1:0] channel_freq_word_zero_ff
);

    // readback mux over the buffered copies; one word wide for any number of channels
    wire [`CFC_FUNC_W*NUM_CH-1:0] func_buf;
    wire [`CFC_FREQ_W*NUM_CH-1:0] freq_buf;
    reg  [`CFC_FREQ_W-1:0]        nxt_rd_data;
    integer                       k;

    always @*
    begin
        nxt_rd_data = 32'h00000000;
        for (k = 0; k < NUM_CH; k = k + 1)
        begin
            // with several channels selected the lowest one answers
            if (rd_ch_sel[k] && (rd_ch_sel & ((1 << k) - 1)) == 0)
            begin
                if (rd_addr == `CFC_ADDR_FUNC)
                begin
                    nxt_rd_data = {8'h00,
                        func_buf[k*`CFC_FUNC_W +: `CFC_FUNC_W]};
                end
                else if (rd_addr == `CFC_ADDR_FREQ)
                begin
                    nxt_rd_data = freq_buf[k*`CFC_FREQ_W +: `CFC_FREQ_W];
                end
                else
                begin
                    nxt_rd_data = 32'h00000000;
                end
            end
        end
    end

    // read answer registered one cycle after the request
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            rd_data_ff  <= 32'h00000000;
            rd_valid_ff <= 1'b0;
        end
        else
        begin
            rd_data_ff  <= rd_en ? nxt_rd_data : 32'h00000000;
            rd_valid_ff <= rd_en;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1)
        begin : gen_ch
            // buffered copy written by the serial port, active copy on update
            reg  [`CFC_FUNC_W-1:0] func_buf_ff;
            reg  [`CFC_FREQ_W-1:0] freq_buf_ff;
            reg  [`CFC_FUNC_W-1:0] func_act_ff;
            wire                   wr_here;
            wire [`CFC_FUNC_W-1:0] nxt_act;

            assign wr_here  = wr_en & wr_ch_sel[g];
            assign func_buf[g*`CFC_FUNC_W +: `CFC_FUNC_W] = func_buf_ff;
            assign freq_buf[g*`CFC_FREQ_W +: `CFC_FREQ_W] = freq_buf_ff;
            // the value that is live from the next edge on
            assign nxt_act  = io_update ? func_buf_ff : func_act_ff;

            // buffered registers; open bits never store
            always @(posedge core_clk)
            begin
                if (srst)
                begin
                    func_buf_ff <= `CFC_FUNC_RESET;
                    freq_buf_ff <= `CFC_FREQ_RESET;
                end
                else if (wr_here && wr_addr == `CFC_ADDR_FUNC)
                begin
                    // bit 10 is stored as written; software keeps it zero
                    func_buf_ff <= wr_data[`CFC_FUNC_W-1:0] &
                                   `CFC_FUNC_MASK;
                end
                else if (wr_here && wr_addr == `CFC_ADDR_FREQ)
                begin
                    freq_buf_ff <= wr_data;
                end
            end

            // commit on update and drive the per-channel control outputs
            always @(posedge core_clk)
            begin
                if (srst)
                begin
                    func_act_ff                    <= `CFC_FUNC_RESET;
                    modulation_type_select_ff[2*g +: 2] <= 2'h0;
                    sweep_en_ff[g]                 <= 1'b0;
                    no_dwell_ff[g]                 <= 1'b0;
                    sweep_ramp_rate_reload_ff[g]   <= 1'b0;
                    dac_fs_ff[2*g +: 2]            <= 2'h3;
                    digital_pd_ff[g]               <= 1'b0;
                    dac_pd_ff[g]                   <= 1'b0;
                    match_pipe_ff[g]               <= 1'b0;
                    sweep_acc_clr_ff[g]            <= 1'b0;
                    phase_acc_clr_ff[g]            <= 1'b0;
                    sine_sel_ff[g]                 <= 1'b0;
                    channel_freq_word_zero_ff[g*`CFC_FREQ_W +: `CFC_FREQ_W]
                        <= `CFC_FREQ_RESET;
                end
                else
                begin
                    func_act_ff <= nxt_act;
                    modulation_type_select_ff[2*g +: 2] <=
                        nxt_act[`CFC_MOD_HI:`CFC_MOD_LO];
                    sweep_en_ff[g] <= nxt_act[`CFC_SWEEP_EN];
                    // no-dwell means nothing while sweep is off
                    no_dwell_ff[g] <= nxt_act[`CFC_NO_DWELL] &
                                      nxt_act[`CFC_SWEEP_EN];
                    // timeout reload lives in the sweep engine; this adds
                    // the update-strobe reload when enabled
                    sweep_ramp_rate_reload_ff[g] <= io_update &
                        func_buf_ff[`CFC_LOAD_SRR];
                    dac_fs_ff[2*g +: 2] <=
                        nxt_act[`CFC_DAC_FS_HI:`CFC_DAC_FS_LO];
                    digital_pd_ff[g] <= nxt_act[`CFC_DIG_PD];
                    dac_pd_ff[g]     <= nxt_act[`CFC_DAC_PD];
                    match_pipe_ff[g] <= nxt_act[`CFC_MATCH_PIPE];
                    // level clear held while the bit stays set, or a
                    // single-cycle pulse for the autoclear on update
                    sweep_acc_clr_ff[g] <= nxt_act[`CFC_CLR_SWEEP] |
                        (io_update & func_buf_ff[`CFC_AUTOCLR_SWEEP]);
                    phase_acc_clr_ff[g] <= nxt_act[`CFC_CLR_PHASE] |
                        (io_update & func_buf_ff[`CFC_AUTOCLR_PHASE]);
                    sine_sel_ff[g] <= nxt_act[`CFC_SINE_SEL];
                    if (io_update)
                    begin
                        channel_freq_word_zero_ff[g*`CFC_FREQ_W +:
                            `CFC_FREQ_W] <= freq_buf_ff;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ### sim/cfc_checker_assertions.sv
// port-level timing checks for the channel control bank
`timescale 1ns/1ps
`default_nettype none
module cfc_checker #(
    parameter NUM_CH = 2
) (
    input wire logic                  core_clk,
    input wire logic                  srst,
    input wire logic                  rd_en,
    input wire logic                  rd_valid_ff,
    input wire logic                  io_update,
    input wire logic [2*NUM_CH-1:0]   modulation_type_select_ff,
    input wire logic [NUM_CH-1:0]     sweep_en_ff,
    input wire logic [NUM_CH-1:0]     no_dwell_ff,
    input wire logic [NUM_CH-1:0]     sweep_ramp_rate_reload_ff,
    input wire logic [2*NUM_CH-1:0]   dac_fs_ff,
    input wire logic [NUM_CH-1:0]     sweep_acc_clr_ff,
    input wire logic [NUM_CH-1:0]     phase_acc_clr_ff,
    input wire logic [32*NUM_CH-1:0]  channel_freq_word_zero_ff
);
    // settings only move on an update edge
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_read_answer: assert property (rd_en |=> rd_valid_ff)
        else $error("read request got no answer");
    a_mod_hold: assert property (!io_update |=> $stable(modulation_type_select_ff))
        else $error("modulation select moved without update");
    a_sweep_hold: assert property (!io_update |=> $stable(sweep_en_ff))
        else $error("sweep enable moved without update");
    a_dwell_gate: assert property ((no_dwell_ff & ~sweep_en_ff) == '0)
        else $error("no-dwell active without sweep");
    a_reload_cause: assert property (|sweep_ramp_rate_reload_ff |-> $past(io_update))
        else $error("ramp reload without update");
    a_fs_reset: assert property ($fell(srst) |-> dac_fs_ff == {NUM_CH{2'b11}})
        else $error("full-scale field wrong after reset");
    a_sweep_clr_rise: assert property (|(sweep_acc_clr_ff & ~$past(sweep_acc_clr_ff)) |-> $past(io_update))
        else $error("sweep clear rose without update");
    a_phase_clr_rise: assert property (|(phase_acc_clr_ff & ~$past(phase_acc_clr_ff)) |-> $past(io_update))
        else $error("phase clear rose without update");
    a_freq_hold: assert property (!io_update |=> $stable(channel_freq_word_zero_ff))
        else $error("frequency word moved without update");
endmodule
bind cfc_channel_function_control cfc_checker #(.NUM_CH(NUM_CH)) cfc_checker_inst (
    .core_clk(core_clk), .srst(srst), .rd_en(rd_en), .rd_valid_ff(rd_valid_ff),
    .io_update(io_update), .sweep_en_ff(sweep_en_ff), .dac_fs_ff(dac_fs_ff),
    .modulation_type_select_ff(modulation_type_select_ff),
    .no_dwell_ff(no_dwell_ff), .sweep_acc_clr_ff(sweep_acc_clr_ff),
    .sweep_ramp_rate_reload_ff(sweep_ramp_rate_reload_ff),
    .phase_acc_clr_ff(phase_acc_clr_ff),
    .channel_freq_word_zero_ff(channel_freq_word_zero_ff));
`default_nettype wire

// ### sim/channel_function_control_test.sv
// random and corner tests of the channel control bank
`timescale 1ns/1ps
`default_nettype none
`include "cfc_consts.vh"
module channel_function_control_test;
    logic        core_clk = 0, srst = 1, wr_en = 0, rd_en = 0, io_update = 0;
    logic [4:0]  wr_addr = 0, rd_addr = 0;
    logic [1:0]  wr_ch_sel = 0, rd_ch_sel = 0;
    logic [31:0] wr_data = 0, rd_data_ff, w [2];
    logic [1:0]  sweep_en_ff, no_dwell_ff, sweep_ramp_rate_reload_ff,
                 digital_pd_ff, dac_pd_ff, match_pipe_ff, sweep_acc_clr_ff,
                 phase_acc_clr_ff, sine_sel_ff;
    logic [3:0]  modulation_type_select_ff, dac_fs_ff;
    logic [63:0] channel_freq_word_zero_ff;
    logic        rd_valid_ff;
    logic [23:0] f [2];
    int          num_errors = 0, check_count = 0;
    always #2.5 core_clk = ~core_clk;
    cfc_channel_function_control #(.NUM_CH(2)) cfc_channel_function_control_inst (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_ch_sel(wr_ch_sel), .wr_data(wr_data), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_ch_sel(rd_ch_sel), .io_update(io_update),
        .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
        .modulation_type_select_ff(modulation_type_select_ff),
        .sweep_en_ff(sweep_en_ff), .no_dwell_ff(no_dwell_ff),
        .sweep_ramp_rate_reload_ff(sweep_ramp_rate_reload_ff),
        .dac_fs_ff(dac_fs_ff), .digital_pd_ff(digital_pd_ff),
        .dac_pd_ff(dac_pd_ff), .match_pipe_ff(match_pipe_ff),
        .sweep_acc_clr_ff(sweep_acc_clr_ff), .sine_sel_ff(sine_sel_ff),
        .phase_acc_clr_ff(phase_acc_clr_ff),
        .channel_freq_word_zero_ff(channel_freq_word_zero_ff));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // requests start at a falling edge; strobes stay up between back-to-back
    // transfers so no strobe is lowered and raised in one time step
    task wr(input logic [4:0] a, input logic [1:0] m, input logic [31:0] d);
        {rd_en, wr_en, wr_addr, wr_ch_sel, wr_data} = {2'b01, a, m, d};
        @(negedge core_clk);
    endtask
    task rd(input logic [4:0] a, input logic [1:0] m, input logic [31:0] e);
        {rd_en, rd_addr, rd_ch_sel} = {1'b1, a, m};
        @(negedge core_clk);
        chk("rd_valid", 1, 32'(rd_valid_ff));
        chk("rd_data", e, rd_data_ff);
    endtask
    // p marks the cycle right after the update edge, when pulses show
    task chan(input int c, input logic p);
        chk("levels", 32'({f[c][23:22], f[c][14], f[c][15] & f[c][14],
            f[c][9:5], f[c][0]}), 32'({modulation_type_select_ff[2*c+:2],
            sweep_en_ff[c], no_dwell_ff[c], dac_fs_ff[2*c+:2], digital_pd_ff[c],
            dac_pd_ff[c], match_pipe_ff[c], sine_sel_ff[c]}));
        chk("clears", 32'({p & f[c][13], f[c][3] | p & f[c][4], f[c][1] |
            p & f[c][2]}), 32'({sweep_ramp_rate_reload_ff[c],
            sweep_acc_clr_ff[c], phase_acc_clr_ff[c]}));
        chk("freq", w[c], channel_freq_word_zero_ff[32*c+:32]);
    endtask
    task upd;
        rd_en = 0;
        io_update = 1;
        @(negedge core_clk);
        io_update = 0;
        chk("rd_idle", 0, rd_data_ff);
        for (int c = 0; c < 2; c++) chan(c, 1);
        @(negedge core_clk);
        for (int c = 0; c < 2; c++) chan(c, 0);
    endtask
    // bit 10 kept clear and open bits written as ones, which must read zero
    initial
    begin
        void'($urandom(8703));
        repeat (12) @(negedge core_clk);
        srst = 0;
        f = '{24'h000300, 24'h000300};
        w = '{32'h0, 32'h0};
        for (int c = 0; c < 2; c++) chan(c, 0);
        rd(`CFC_ADDR_FUNC, 2'b10, 32'h00000300);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            for (int c = 0; c < 2; c++)
            begin
                f[c] = i == 6 ? 24'hc0e3ff : i == 7 ? 24'h0 :
                    {i[1:0], 22'($urandom) & 22'h00e3ff};
                w[c] = $urandom;
                wr(`CFC_ADDR_FUNC, 2'(1 << c), {8'hff, f[c] | 24'h3f1800});
                wr(`CFC_ADDR_FREQ, 2'(1 << c), w[c]);
            end
            wr_en = 0;
            rd(`CFC_ADDR_FUNC, 2'b01, 32'(f[0]));
            rd(`CFC_ADDR_FREQ, 2'b10, w[1]);
            rd(`CFC_ADDR_FREQ, 2'b11, w[0]);
            rd(`CFC_ADDR_FUNC, 2'b00, 32'h0);
            upd();
        end
        $display("test random done");
        rd(5'h05, 2'b01, 32'h0);
        $display("test unmapped done");
        conclude();
    end
    // watchdog: the tests need well under a microsecond
    initial
    begin
        #5000;
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
